// >>> bsc_pkg.sv
// Purpose: Shared constants and types for the bridge secondary control block.
// Assumes: APB register access with 32-bit data and byte addresses.
// Notes: Offsets, field positions, reset values and counts are named here once.
package bsc_pkg;

  // Register byte offsets.
  localparam logic [11:0] BSC_CTRL_OFS = 12'h03c;
  localparam logic [11:0] BSC_STAT_OFS = 12'h040;
  localparam logic [11:0] BSC_MASK_OFS = 12'h044;
  localparam logic [11:0] BSC_TMR_OFS = 12'h048;
  localparam logic [11:0] BSC_CFG_OFS = 12'h04c;

  // Bridge control register field positions.
  localparam int BSC_DISCARD_SERR_BIT = 27;
  localparam int BSC_DISCARD_STAT_BIT = 26;
  localparam int BSC_SEC_DISC_SEL_BIT = 25;
  localparam int BSC_PRI_DISC_SEL_BIT = 24;
  localparam int BSC_FAST_B2B_BIT = 23;
  localparam int BSC_SEC_RESET_BIT = 22;
  localparam int BSC_MA_MODE_BIT = 21;
  localparam int BSC_VGA_FULL_BIT = 20;
  localparam int BSC_VGA_EN_BIT = 19;

  // Configuration register field positions.
  localparam int BSC_CFG_FATAL_BIT = 0;
  localparam int BSC_CFG_SERR_BIT = 1;
  localparam int BSC_CFG_PCI_MODE_BIT = 2;

  // Interrupt status and mask bit positions.
  localparam int BSC_IRQ_DISCARD_BIT = 0;
  localparam int BSC_IRQ_ERRMSG_BIT = 1;
  localparam int BSC_IRQ_TABORT_BIT = 2;
  localparam int BSC_IRQ_W = 3;

  // Reset values.
  localparam logic [31:0] BSC_CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] BSC_CFG_RST = 3'h4;
  localparam logic [2:0] BSC_MASK_RST = 3'h0;

  // Discard timer lengths in PCI clocks.
  localparam int BSC_DISC_LONG_CNT = 32768;
  localparam int BSC_DISC_SHORT_CNT = 1024;
  localparam int BSC_CNT_W = 16;

  // VGA I/O decode windows on address bits 9:0.
  localparam logic [9:0] BSC_VGA_A_LO = 10'h3b0;
  localparam logic [9:0] BSC_VGA_A_HI = 10'h3bb;
  localparam logic [9:0] BSC_VGA_B_LO = 10'h3c0;
  localparam logic [9:0] BSC_VGA_B_HI = 10'h3df;

  // Value returned for reads that ended in an unsupported request.
  localparam logic [31:0] BSC_UR_READ_DATA = 32'hffff_ffff;

  // Error message toward the upstream link.
  typedef struct packed {
    logic valid;
    logic fatal;
  } bsc_errmsg_type;

  // Unsupported-request completion arriving from upstream.
  typedef struct packed {
    logic valid;
    logic is_read;
  } bsc_ur_type;

endpackage

// >>> bsc_ctrl.sv
// Purpose: Secondary-side control of a PCIe-to-PCI bridge: discard timer,
//   secondary reset, master-abort reporting and VGA I/O decode.
// Assumes: APB slave on clk; pci_clk is sampled, not used as a clock.
// Notes: Event inputs are one-cycle pulses from logic on clk.
// How it works
// R1: Select bit picks 2^15 or 2^10 clocks.
// R2: Timer starts when completion reaches queue head.
// R3: Expiry without retry drops transaction, sets flag.
// R4: Primary discard select reads zero always.
// R5: Fast back-to-back enable reads zero always.
// R6: Reset bit set drives secondary reset low.
// R7: Reset bit holds secondary logic in default.
// R8: Reset bit leaves registers and upstream untouched.
// R9: Software times the reset pulse width itself.
// R10: Mode clear: UR reads all ones, writes complete.
// R11: Mode clear: posted master-abort silently dropped.
// R12: Mode set: UR answered with target-abort.
// R13: Mode set: posted abort sends error if enabled.
// R14: Fatal severity selectable only with advanced reporting.
// R15: Full decode compares 16 bits, else 10 bits.
// R16: Full decode matters only with VGA enabled.
// R17: Discard flag set on expiry, write-one clears.
// R18: VGA windows 3b0-3bb, 3c0-3df, upper half zero.
// R19: Retry completion stops and clears the timer.
`timescale 1ns/1ps
`default_nettype none
module bsc_ctrl #(
  parameter int DISC_LONG_CNT = bsc_pkg::BSC_DISC_LONG_CNT,
  parameter int DISC_SHORT_CNT = bsc_pkg::BSC_DISC_SHORT_CNT,
  parameter bit AER_SUPPORTED = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pci_clk,
  input wire logic dt_cpl_at_head,
  input wire logic dt_retry_done,
  output logic dt_discard,
  output logic pci_rst_n,
  output logic sec_init,
  input wire bsc_pkg::bsc_ur_type ur_cpl,
  output logic ur_read_ones,
  output logic [31:0] ur_read_data,
  output logic ur_write_done,
  output logic ur_target_abort,
  input wire logic posted_ma,
  output logic posted_drop,
  output bsc_pkg::bsc_errmsg_type err_msg,
  input wire logic io_valid,
  input wire logic [31:0] io_addr,
  output logic vga_hit,
  output logic irq
);
  import bsc_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Discard timer states.
  typedef enum logic {DT_IDLE, DT_RUN} bsc_dt_state_type;

  logic [31:0] ctrl_ff; // Bridge control bits, only the documented ones are kept.
  logic [2:0] cfg_ff; // Severity select, command SERR enable, PCI mode.
  logic [BSC_IRQ_W-1:0] stat_ff; // Sticky interrupt status, cleared on read.
  logic [BSC_IRQ_W-1:0] mask_ff; // Interrupt mask.
  logic [31:0] prdata_ff; // Read data captured in the setup cycle.
  logic pready_ff; // Zero-wait ready.
  logic pslverr_ff; // Error for unmapped addresses.
  logic pci_s1_ff, pci_s2_ff, pci_s3_ff; // Link clock synchroniser and history.
  bsc_dt_state_type dt_state_ff; // Discard timer state.
  logic [BSC_CNT_W-1:0] cnt_ff; // PCI clocks counted so far.
  logic dt_discard_ff; // Discard pulse.
  logic pci_rst_n_ff, sec_init_ff; // Secondary reset drive and init level.
  logic ur_ones_ff, ur_wdone_ff, ur_tabort_ff; // Unsupported-request answers.
  logic [31:0] ur_data_ff; // Fill data for aborted reads.
  logic posted_drop_ff; // Silent drop of an aborted posted write.
  bsc_errmsg_type err_msg_ff; // Error message request.
  logic vga_hit_ff; // VGA decode result.
  logic irq_ff; // Interrupt level.

  logic wr_en, rd_en, pci_edge, expire, mapped;
  logic [BSC_CNT_W-1:0] last_cnt;
  logic vga_low_match, vga_match;
  logic [31:0] ctrl_rd;

  // Bus phases: an access completes at the edge where penable and pready are high.
  assign wr_en = psel & penable & pready_ff & pwrite;
  assign rd_en = psel & penable & pready_ff & ~pwrite;
  assign mapped = (paddr == BSC_CTRL_OFS) | (paddr == BSC_STAT_OFS) |
                  (paddr == BSC_MASK_OFS) | (paddr == BSC_TMR_OFS) |
                  (paddr == BSC_CFG_OFS);

  // Control register read view; read-only fields are forced low.
  always_comb begin
    ctrl_rd = ctrl_ff;
    ctrl_rd[BSC_PRI_DISC_SEL_BIT] = 1'b0; // R4
    ctrl_rd[BSC_FAST_B2B_BIT] = 1'b0; // R5
  end

  // Ready is raised in the setup cycle so every access ends after one cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        // Read data is latched at setup so it stands during the access phase.
        case (paddr)
          BSC_CTRL_OFS: prdata_ff <= ctrl_rd;
          BSC_STAT_OFS: prdata_ff <= {29'h0000_0000, stat_ff};
          BSC_MASK_OFS: prdata_ff <= {29'h0000_0000, mask_ff};
          BSC_TMR_OFS: prdata_ff <= {cnt_ff, 15'h0000, dt_state_ff == DT_RUN};
          BSC_CFG_OFS: prdata_ff <= {29'h0000_0000, cfg_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; the secondary reset bit clears no control bit, only the timer count and state.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= BSC_CTRL_RST;
    end else begin
      if (wr_en && paddr == BSC_CTRL_OFS) begin
        ctrl_ff[BSC_DISCARD_SERR_BIT] <= pwdata[BSC_DISCARD_SERR_BIT];
        ctrl_ff[BSC_SEC_DISC_SEL_BIT] <= pwdata[BSC_SEC_DISC_SEL_BIT];
        ctrl_ff[BSC_SEC_RESET_BIT] <= pwdata[BSC_SEC_RESET_BIT];
        ctrl_ff[BSC_MA_MODE_BIT] <= pwdata[BSC_MA_MODE_BIT];
        ctrl_ff[BSC_VGA_FULL_BIT] <= pwdata[BSC_VGA_FULL_BIT];
        ctrl_ff[BSC_VGA_EN_BIT] <= pwdata[BSC_VGA_EN_BIT];
        // Writing one clears the discard flag.
        if (pwdata[BSC_DISCARD_STAT_BIT]) begin
          ctrl_ff[BSC_DISCARD_STAT_BIT] <= 1'b0; // R17
        end
      end
      // A discard in the same cycle as the clear wins.
      if (expire) begin
        ctrl_ff[BSC_DISCARD_STAT_BIT] <= 1'b1; // R3 R17
      end
    end
  end

  // Configuration and mask registers; only srst clears them, never the reset bit.
  always_ff @(posedge clk) begin
    if (srst) begin // R8
      cfg_ff <= BSC_CFG_RST;
      mask_ff <= BSC_MASK_RST;
    end else begin
      if (wr_en && paddr == BSC_CFG_OFS) begin
        cfg_ff <= pwdata[2:0];
      end
      if (wr_en && paddr == BSC_MASK_OFS) begin
        mask_ff <= pwdata[BSC_IRQ_W-1:0];
      end
    end
  end

  // Sticky status: a read clears it, a new event in that cycle survives.
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= ((rd_en && paddr == BSC_STAT_OFS) ? '0 : stat_ff) |
                 {ur_tabort_ff, err_msg_ff.valid, dt_discard_ff};
    end
  end

  // Interrupt output is high while any unmasked status bit is set.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // Link clock passes two flip-flops; the third stage only serves edge finding.
  always_ff @(posedge clk) begin
    if (srst) begin
      pci_s1_ff <= 1'b0;
      pci_s2_ff <= 1'b0;
      pci_s3_ff <= 1'b0;
    end else begin
      pci_s1_ff <= pci_clk;
      pci_s2_ff <= pci_s1_ff;
      pci_s3_ff <= pci_s2_ff;
    end
  end
  assign pci_edge = pci_s2_ff & ~pci_s3_ff;

  // Terminal count follows the secondary discard select bit.
  assign last_cnt = ctrl_ff[BSC_SEC_DISC_SEL_BIT] ?
                    BSC_CNT_W'(DISC_SHORT_CNT - 1) :
                    BSC_CNT_W'(DISC_LONG_CNT - 1); // R1
  assign expire = (dt_state_ff == DT_RUN) & ~dt_retry_done & pci_edge &
                  (cnt_ff == last_cnt) & ~ctrl_ff[BSC_SEC_RESET_BIT];

  // Discard timer: waits for the completion at queue head, then counts PCI clocks.
  always_ff @(posedge clk) begin
    if (srst) begin
      dt_state_ff <= DT_IDLE;
      cnt_ff <= '0;
      dt_discard_ff <= 1'b0;
    end else begin
      dt_discard_ff <= expire; // R3
      if (ctrl_ff[BSC_SEC_RESET_BIT]) begin
        // Secondary side held in its default state.
        dt_state_ff <= DT_IDLE; // R7
        cnt_ff <= '0;
      end else begin
        case (dt_state_ff)
          DT_IDLE: begin
            if (dt_cpl_at_head) begin
              dt_state_ff <= DT_RUN; // R2
              cnt_ff <= '0;
            end
          end
          DT_RUN: begin
            if (dt_retry_done) begin
              // The master came back in time; the timer stops and clears.
              dt_state_ff <= DT_IDLE; // R19
              cnt_ff <= '0;
            end else if (expire) begin
              dt_state_ff <= DT_IDLE; // R3
              cnt_ff <= '0;
            end else if (pci_edge) begin
              cnt_ff <= cnt_ff + 1'b1; // R1
            end
          end
          default: begin
            dt_state_ff <= DT_IDLE;
            cnt_ff <= '0;
          end
        endcase
      end
    end
  end

  // Secondary reset follows the control bit; pulse width is software's job.
  always_ff @(posedge clk) begin
    if (srst) begin
      pci_rst_n_ff <= 1'b1;
      sec_init_ff <= 1'b0;
    end else begin
      pci_rst_n_ff <= ~ctrl_ff[BSC_SEC_RESET_BIT]; // R6 R9
      sec_init_ff <= ctrl_ff[BSC_SEC_RESET_BIT]; // R7
    end
  end

  // Master-abort handling; the secondary reset bit does not gate any of these answers.
  always_ff @(posedge clk) begin
    if (srst) begin
      ur_ones_ff <= 1'b0;
      ur_wdone_ff <= 1'b0;
      ur_tabort_ff <= 1'b0;
      ur_data_ff <= 32'h0000_0000;
      posted_drop_ff <= 1'b0;
      err_msg_ff <= '0;
    end else begin
      ur_ones_ff <= ur_cpl.valid & ur_cpl.is_read & cfg_ff[BSC_CFG_PCI_MODE_BIT] &
                    ~ctrl_ff[BSC_MA_MODE_BIT]; // R10
      ur_wdone_ff <= ur_cpl.valid & ~ur_cpl.is_read & cfg_ff[BSC_CFG_PCI_MODE_BIT] &
                     ~ctrl_ff[BSC_MA_MODE_BIT]; // R10
      ur_tabort_ff <= ur_cpl.valid & cfg_ff[BSC_CFG_PCI_MODE_BIT] &
                      ctrl_ff[BSC_MA_MODE_BIT]; // R12
      if (ur_cpl.valid & ur_cpl.is_read & ~ctrl_ff[BSC_MA_MODE_BIT]) begin
        ur_data_ff <= BSC_UR_READ_DATA; // R10
      end
      posted_drop_ff <= posted_ma & ~ctrl_ff[BSC_MA_MODE_BIT]; // R11
      err_msg_ff.valid <= posted_ma & ctrl_ff[BSC_MA_MODE_BIT] &
                          cfg_ff[BSC_CFG_SERR_BIT]; // R13
      // Fatal severity only exists where advanced reporting is built in.
      err_msg_ff.fatal <= AER_SUPPORTED & cfg_ff[BSC_CFG_FATAL_BIT]; // R14
    end
  end

  // VGA I/O decode: 10-bit compare with aliases unless full decode is on.
  assign vga_low_match = (io_addr[9:0] >= BSC_VGA_A_LO && io_addr[9:0] <= BSC_VGA_A_HI) ||
                         (io_addr[9:0] >= BSC_VGA_B_LO && io_addr[9:0] <= BSC_VGA_B_HI);
  assign vga_match = vga_low_match && io_addr[31:16] == 16'h0000 && // R18
                     (~ctrl_ff[BSC_VGA_FULL_BIT] || io_addr[15:10] == 6'h00); // R15
  always_ff @(posedge clk) begin
    if (srst) begin
      vga_hit_ff <= 1'b0;
    end else begin
      vga_hit_ff <= io_valid & ctrl_ff[BSC_VGA_EN_BIT] & vga_match; // R16
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dt_discard = dt_discard_ff;
  assign pci_rst_n = pci_rst_n_ff;
  assign sec_init = sec_init_ff;
  assign ur_read_ones = ur_ones_ff;
  assign ur_read_data = ur_data_ff;
  assign ur_write_done = ur_wdone_ff;
  assign ur_target_abort = ur_tabort_ff;
  assign posted_drop = posted_drop_ff;
  assign err_msg = err_msg_ff;
  assign vga_hit = vga_hit_ff;
  assign irq = irq_ff;

  // The discard pulse follows the terminal count chosen by the select bit.
  property p_disc_len;
    $rose(dt_discard_ff) |-> $past(cnt_ff) == ($past(ctrl_ff[BSC_SEC_DISC_SEL_BIT]) ?
      BSC_CNT_W'(DISC_SHORT_CNT - 1) : BSC_CNT_W'(DISC_LONG_CNT - 1));
  endproperty
  a_disc_len: assert property (p_disc_len) else $error("discard at wrong count"); // R1

  // The timer never leaves idle without a completion at the queue head.
  property p_start;
    (dt_state_ff == DT_IDLE && !dt_cpl_at_head) |=> dt_state_ff == DT_IDLE;
  endproperty
  a_start: assert property (p_start) else $error("timer started without cause"); // R2

  // A discard sets the status flag and the interrupt status bit.
  property p_disc_flag;
    dt_discard_ff |-> ctrl_ff[BSC_DISCARD_STAT_BIT] ##1 stat_ff[BSC_IRQ_DISCARD_BIT];
  endproperty
  a_disc_flag: assert property (p_disc_flag) else $error("discard flag not set"); // R3 R17

  // Read-only zero fields of the control register.
  property p_ro_zero;
    (psel && !penable && !pwrite && paddr == BSC_CTRL_OFS) |=>
      prdata[BSC_PRI_DISC_SEL_BIT] == 1'b0 && prdata[BSC_FAST_B2B_BIT] == 1'b0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("read-only bit read as one"); // R4 R5

  // Secondary reset drive and init level track the control bit one cycle later.
  property p_sec_rst;
    ctrl_ff[BSC_SEC_RESET_BIT] |=> !pci_rst_n && sec_init && dt_state_ff == DT_IDLE;
  endproperty
  a_sec_rst: assert property (p_sec_rst) else $error("secondary reset not applied"); // R6 R7

  // Setting the secondary reset bit leaves the other registers alone.
  property p_keep_regs;
    $rose(ctrl_ff[BSC_SEC_RESET_BIT]) |-> $stable(mask_ff) && $stable(cfg_ff);
  endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("reset bit changed registers"); // R8

  // Unsupported read with reporting off returns all ones.
  property p_ur_read;
    (ur_cpl.valid && ur_cpl.is_read && !ctrl_ff[BSC_MA_MODE_BIT] &&
     cfg_ff[BSC_CFG_PCI_MODE_BIT]) |=> ur_read_ones && ur_read_data == BSC_UR_READ_DATA;
  endproperty
  a_ur_read: assert property (p_ur_read) else $error("UR read not filled"); // R10

  // Posted master-abort with reporting off is dropped without an error message.
  property p_posted_drop;
    (posted_ma && !ctrl_ff[BSC_MA_MODE_BIT]) |=> posted_drop && !err_msg.valid;
  endproperty
  a_posted_drop: assert property (p_posted_drop) else $error("posted abort not dropped"); // R11

  // With reporting on, an unsupported completion becomes a target-abort.
  property p_tabort;
    (ur_cpl.valid && ctrl_ff[BSC_MA_MODE_BIT] && cfg_ff[BSC_CFG_PCI_MODE_BIT]) |=>
      ur_target_abort && !ur_read_ones;
  endproperty
  a_tabort: assert property (p_tabort) else $error("target-abort missing"); // R12

  // Error messages only with reporting on and SERR enabled.
  property p_errmsg;
    err_msg.valid |-> $past(posted_ma) && $past(ctrl_ff[BSC_MA_MODE_BIT]) &&
      $past(cfg_ff[BSC_CFG_SERR_BIT]) && (err_msg.fatal -> AER_SUPPORTED);
  endproperty
  a_errmsg: assert property (p_errmsg) else $error("error message without cause"); // R13 R14

  // VGA hits need the enable, the upper half zero and the full compare when set.
  property p_vga;
    vga_hit |-> $past(ctrl_ff[BSC_VGA_EN_BIT]) && $past(io_addr[31:16]) == 16'h0000 &&
      (!$past(ctrl_ff[BSC_VGA_FULL_BIT]) || $past(io_addr[15:10]) == 6'h00);
  endproperty
  a_vga: assert property (p_vga) else $error("bad VGA decode"); // R15 R16 R18

  // A completed retry stops and clears the timer.
  property p_retry;
    (dt_state_ff == DT_RUN && dt_retry_done) |=> dt_state_ff == DT_IDLE && cnt_ff == '0;
  endproperty
  a_retry: assert property (p_retry) else $error("timer kept running"); // R19

endmodule
`default_nettype wire

// >>> bsc_pci_partner.sv
// Purpose: Far-side model: secondary PCI clock and one delayed-transaction master.
// Assumes: pci_clk period is 80 ns and it stays low while run is low.
// Notes: The master counts pci_clk rising edges, sampled on clk.
`timescale 1ns/1ps
`default_nettype none
module bsc_pci_partner (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic start,
  input wire logic retry_en,
  input wire logic [15:0] retry_at,
  input wire logic pci_rst_n,
  output logic pci_clk,
  output logic dt_cpl_at_head,
  output logic dt_retry_done
);
  logic pclk = 1'b0; // Oscillator state, parked low between bursts.
  logic pclk_prev_ff; // Previous pci_clk sample, used to find rising edges.
  logic busy_ff; // A delayed request waits for its repeat.
  logic [15:0] edges_ff; // PCI clock edges since the completion reached the head.
  // The bus clock only runs while the bench asks for bus activity.
  always #40 pclk = run ? ~pclk : 1'b0;
  assign pci_clk = pclk;
  // The master repeats its request after retry_at PCI clocks when told to.
  always_ff @(posedge clk) begin
    pclk_prev_ff <= pclk;
    dt_cpl_at_head <= 1'b0;
    dt_retry_done <= 1'b0;
    if (srst || !pci_rst_n) begin
      // A bus reset makes the master forget its request.
      busy_ff <= 1'b0;
      edges_ff <= '0;
    end else if (start) begin
      busy_ff <= 1'b1;
      edges_ff <= '0;
      dt_cpl_at_head <= 1'b1;
    end else if (busy_ff && pclk && !pclk_prev_ff) begin
      edges_ff <= edges_ff + 16'h1;
      if (retry_en && (edges_ff + 16'h1 == retry_at)) begin
        dt_retry_done <= 1'b1;
        busy_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the bridge secondary control block.
// Assumes: Discard counts shortened to 64 and 8 PCI clocks.
// Notes: Every scenario is one task that drives and judges by itself.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bsc_pkg::*;
  localparam int LONG_N = 64; // Shortened long discard count.
  localparam int SHORT_N = 8; // Shortened short discard count.
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, io_addr = 32'h0, prdata, ur_read_data, rd;
  logic pready, pslverr, err, pci_clk, cpl_head, retry_done, dt_discard;
  logic pci_rst_n, sec_init, ur_read_ones, ur_write_done, ur_target_abort;
  logic posted_ma = 1'b0, io_valid = 1'b0, posted_drop, vga_hit, irq;
  logic run = 1'b0, start = 1'b0, retry_en = 1'b0;
  logic [15:0] retry_at = 16'h0;
  bsc_ur_type ur_cpl = '0;
  bsc_errmsg_type err_msg;
  int n_errors = 0, tests_run = 0, n_disc = 0;
  // The system clock toggles every 4 ns, giving an 8 ns period.
  always #4 clk = ~clk;
  // Discard pulses are counted so a missing or extra one shows up.
  always @(posedge clk) if (dt_discard === 1'b1) n_disc <= n_disc + 1;
  bsc_ctrl #(.DISC_LONG_CNT(LONG_N), .DISC_SHORT_CNT(SHORT_N), .AER_SUPPORTED(1'b1))
    bsc_ctrl_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pci_clk(pci_clk), .dt_cpl_at_head(cpl_head),
    .dt_retry_done(retry_done), .dt_discard(dt_discard), .pci_rst_n(pci_rst_n),
    .sec_init(sec_init), .ur_cpl(ur_cpl), .ur_read_ones(ur_read_ones),
    .ur_read_data(ur_read_data), .ur_write_done(ur_write_done),
    .ur_target_abort(ur_target_abort), .posted_ma(posted_ma), .posted_drop(posted_drop),
    .err_msg(err_msg), .io_valid(io_valid), .io_addr(io_addr), .vga_hit(vga_hit), .irq(irq));
  bsc_pci_partner bsc_pci_partner_inst (.clk(clk), .srst(srst), .run(run), .start(start),
    .retry_en(retry_en), .retry_at(retry_at), .pci_rst_n(pci_rst_n), .pci_clk(pci_clk),
    .dt_cpl_at_head(cpl_head), .dt_retry_done(retry_done));
  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      n_errors++;
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) check("pready", 0, 1);
  endtask
  // Drives one cycle of event inputs, then waits for the registered answer.
  task automatic ev(input logic [1:0] u, input logic p, input logic v, input logic [31:0] a);
    @(posedge clk);
    ur_cpl <= u;
    posted_ma <= p;
    io_valid <= v;
    io_addr <= a;
    @(posedge clk);
    ur_cpl <= '0;
    posted_ma <= 1'b0;
    io_valid <= 1'b0;
    #1;
  endtask
  // Reset values, read-only bits, the secondary reset and an unmapped address.
  task automatic t_regs;
    check("pci_rst_n", pci_rst_n, 1);
    apb(0, BSC_CTRL_OFS, 0);
    check("ctrl_rst", rd, BSC_CTRL_RST);
    apb(0, BSC_MASK_OFS, 0);
    check("mask_rst", rd, 32'(BSC_MASK_RST));
    apb(1, BSC_CTRL_OFS, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    #1;
    check("pci_rst_n", pci_rst_n, 0);
    check("sec_init", sec_init, 1);
    apb(0, BSC_CTRL_OFS, 0);
    check("ctrl_ro", rd, 32'h0a78_0000);
    apb(0, BSC_CFG_OFS, 0);
    check("cfg_kept", rd, 32'(BSC_CFG_RST));
    // Software keeps the reset bit set long enough for the bus reset pulse.
    repeat (40) @(posedge clk);
    apb(1, BSC_CTRL_OFS, 0);
    repeat (2) @(posedge clk);
    #1;
    check("pci_rst_n", pci_rst_n, 1);
    check("sec_init", sec_init, 0);
    apb(0, 12'h050, 0);
    check("unmapped_err", err, 1);
    check("unmapped_data", rd, 0);
    $display("test regs done");
  endtask
  // Discard timer: mode 0 expires, mode 1 is retried, mode 2 is reset mid-count.
  task automatic t_disc(input logic sel, input int mode);
    int n, t, base;
    n = sel ? SHORT_N : LONG_N;
    base = n_disc;
    apb(1, BSC_MASK_OFS, 32'h1);
    apb(1, BSC_CTRL_OFS, 32'(sel) << BSC_SEC_DISC_SEL_BIT);
    @(posedge clk);
    retry_en <= (mode == 1);
    retry_at <= 16'(n - 2);
    start <= 1'b1;
    run <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    if (mode == 2) apb(1, BSC_CTRL_OFS, (32'(sel) << BSC_SEC_DISC_SEL_BIT) | 32'h0040_0000);
    t = 0;
    while (n_disc == base && t < n * 10 + 60) begin
      @(posedge clk);
      t++;
    end
    if (mode != 0) begin
      check("no_discard", n_disc - base, 0);
      apb(0, BSC_TMR_OFS, 0);
      check("tmr_idle", rd & 32'h1, 0);
    end else begin
      check("discard_time", (t > n * 10 - 12) && (t < n * 10 + 14), 1);
      repeat (3) @(posedge clk);
      #1;
      check("irq_set", irq, 1);
      apb(0, BSC_CTRL_OFS, 0);
      check("disc_flag", rd, (32'h1 << 26) | (32'(sel) << 25));
      apb(0, BSC_STAT_OFS, 0);
      check("stat", rd, 1);
      apb(0, BSC_STAT_OFS, 0);
      check("stat_clr", rd, 0);
      apb(1, BSC_CTRL_OFS, (32'h1 << 26) | (32'(sel) << 25));
      apb(0, BSC_CTRL_OFS, 0);
      check("disc_w1c", rd, 32'(sel) << 25);
      check("irq_clr", irq, 0);
    end
    apb(1, BSC_CTRL_OFS, 0);
    run <= 1'b0;
    $display("test discard sel %0d mode %0d done", sel, mode);
  endtask
  // Master-abort mode against every SERR and severity setting.
  task automatic t_ma;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1, BSC_CTRL_OFS, 32'(m) << BSC_MA_MODE_BIT);
        apb(1, BSC_CFG_OFS, 32'h4 | 32'(c));
        ev(2'b11, 0, 0, 0);
        check("ur_read_ones", ur_read_ones, m == 0);
        check("ur_abort_rd", ur_target_abort, m == 1);
        if (m == 0) check("ur_data", ur_read_data, BSC_UR_READ_DATA);
        ev(2'b10, 0, 0, 0);
        check("ur_write_done", ur_write_done, m == 0);
        check("ur_abort_wr", ur_target_abort, m == 1);
        ev(2'b00, 1, 0, 0);
        check("posted_drop", posted_drop, m == 0);
        check("err_msg", {err_msg.valid, err_msg.valid & err_msg.fatal},
              {m == 1 && c[1], m == 1 && c[1] && c[0]});
      end
    end
    // Without PCI mode an unsupported read gets no all-ones answer.
    apb(1, BSC_CTRL_OFS, 0);
    apb(1, BSC_CFG_OFS, 0);
    ev(2'b11, 0, 0, 0);
    check("ur_ones_nopci", ur_read_ones, 0);
    apb(1, BSC_MASK_OFS, 32'h6);
    // The interrupt level follows the new mask one cycle after the write.
    @(posedge clk);
    #1;
    check("irq_ma", irq, 1);
    apb(0, BSC_STAT_OFS, 0);
    check("stat_ma", rd, 32'h6);
    apb(1, BSC_CTRL_OFS, 0);
    $display("test master abort done");
  endtask
  // VGA decode for each enable and width setting over edge addresses.
  task automatic t_vga;
    logic [31:0] ad [9] = '{32'h3b0, 32'h3bb, 32'h3bc, 32'h3c0, 32'h3df, 32'h3e0,
                            32'h7b0, 32'h1_03c0, 32'h3af};
    logic hit;
    for (int e = 0; e < 2; e++) begin
      for (int f = 0; f < 2; f++) begin
        apb(1, BSC_CTRL_OFS, (32'(e) << BSC_VGA_EN_BIT) | (32'(f) << BSC_VGA_FULL_BIT));
        for (int i = 0; i < 9; i++) begin
          hit = e == 1 && ad[i][31:16] == 16'h0 && (f == 0 || ad[i][15:10] == 6'h0) &&
                ((ad[i][9:0] >= 10'h3b0 && ad[i][9:0] <= 10'h3bb) ||
                 (ad[i][9:0] >= 10'h3c0 && ad[i][9:0] <= 10'h3df));
          ev(2'b00, 0, 1, ad[i]);
          check("vga_hit", vga_hit, hit);
        end
      end
    end
    $display("test vga done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 100 us.
  initial begin
    #500000;
    n_errors++;
    results;
  end
  // Main sequence after a four-cycle reset.
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_disc(1'b0, 0);
    t_disc(1'b1, 0);
    t_disc(1'b1, 1);
    t_disc(1'b0, 1);
    t_disc(1'b1, 2);
    t_ma;
    t_vga;
    results;
  end
endmodule
`default_nettype wire
